// >>> hw/fracdiv_params.svh
`ifndef FRACDIV_PARAMS_SVH
`define FRACDIV_PARAMS_SVH

// serial frame: 8 address bits then 40 data bits, msb first
`define FRAME_BITS 6'h30
`define ADDR_HI 47
`define ADDR_LO 40
`define DATA_W 40

// register offsets
`define OFS_DIVIDER 8'h06
`define OFS_SETUP 8'h07
`define OFS_RESTART 8'h08
`define OFS_GAIN 8'h0C

// divider register fields
`define INT_HI 39
`define INT_LO 32
`define FRAC_HI 31
`define FRAC_LO 4
`define DIV_POWER_BITS 4'hE

// modulation setup register fields
`define DITH_ORD_HI 39
`define DITH_ORD_LO 37
`define DITH_SHIFT_HI 36
`define DITH_SHIFT_LO 32
`define MASH_HI 31
`define MASH_LO 29
`define BAND_HI 28
`define BAND_LO 24
`define SYNC_INH_BIT 23
`define INTERP_HI 22
`define INTERP_LO 21

// restart and gain band bits
`define RESTART_BIT 14
`define GAIN_BIT 0

// field limits
`define FRAC_WIDTH 28
`define MAX_DITH_ORD 3'h5
`define MAX_MASH_ORD 3'h4
`define GAIN_BAND_LO 5'h0E
`define GAIN_BAND_HI 5'h1B
`define PHASE_BITS 3

// dither generator seed, any nonzero value keeps the sequence running
`define LFSR_SEED 16'hACE1

// host serial clock half period in reference cycles
`define SCLK_HALF_CYC 4

`endif

// >>> hw/fracdiv_pkg.sv
package fracdiv_pkg;

   typedef enum logic [1:0] {
      H_IDLE,
      H_LOAD,
      H_SHIFT,
      H_GAP
   } host_state_e;

   typedef logic signed [5:0] div_step_t;
   typedef logic [47:0] frame_t;

endpackage

// >>> hw/serial_cfg_if.sv
`timescale 1ns/1ps
interface serial_cfg_if;
   logic sclk;
   logic cs_n;
   logic mosi;

   modport host (
      output sclk,
      output cs_n,
      output mosi
   );

   modport dev (
      input sclk,
      input cs_n,
      input mosi
   );
endinterface

// >>> hw/fractional_divider_modulation_ctrl.sv
// Operation
// - dither_order zero disables, else sets dither order
// - add zero-mean shaped random dither each calculation
// - host keeps dither_order at five or less
// - host zeroes dither without modulation, else matches
// - dither shifted left by dither_shift_amount
// - host keeps shift amount above dither_order
// - noise_shaper_order zero disables modulation
// - modulate floor/ceiling unless ratio exact
// - order one first-order; host limits to four
// - osc_band_select drives oscillator range
// - host sets osc_gain_band for bands 14..27
// - startup_sync_inhibit suppresses startup sync pulse
// - phase_interp_order picks eight, four, two, none
// - eight phases realize eighths without modulation
// - two phases or no interpolation drop fraction low bits
// - full 28-bit feedback_fraction used with eight or four phases
// - host pulses feedback_div_restart after divider or noise_shaper_order changes
`timescale 1ns/1ps
`include "fracdiv_params.svh"
module fractional_divider_modulation_ctrl #(
   parameter int FRAC_W = `FRAC_WIDTH
) (
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RST_N_IN,
   // one pulse per feedback divider output cycle
   input wire logic FB_CYCLE_IN,
   // serial configuration link
   serial_cfg_if.dev CFG_IF,
   // divider control
   output fracdiv_pkg::div_step_t DIV_STEP_OUT,
   output logic [2:0] FRAC_PHASE_OUT,
   output logic [1:0] INTERP_ORDER_OUT,
   output logic DIV_RESTART_OUT,
   // oscillator and sync
   output logic [4:0] OSC_BAND_OUT,
   output logic OSC_GAIN_BAND_OUT,
   output logic SYNC_PULSE_OUT
);

   // serial slave: inputs are synchronous, so edges come from a plain history flop
   logic sclk_prev_reg;
   logic cs_prev_reg;
   fracdiv_pkg::frame_t shift_reg;
   logic [5:0] bit_cnt_reg;
   logic [`DATA_W-1:0] setup_reg;
   logic [FRAC_W-1:0] frac_reg;
   logic restart_reg;
   logic gain_reg;

   wire sclk_rise = CFG_IF.sclk & ~sclk_prev_reg & ~CFG_IF.cs_n;
   wire cs_rise = CFG_IF.cs_n & ~cs_prev_reg;
   wire frame_ok = cs_rise & (bit_cnt_reg == `FRAME_BITS);
   wire [7:0] wr_addr = shift_reg[`ADDR_HI:`ADDR_LO];
   wire [`DATA_W-1:0] wr_data = shift_reg[`DATA_W-1:0];

   always_ff @(posedge REF_CLK_IN) begin
      if (!RST_N_IN) begin
         sclk_prev_reg <= 1'b0;
         cs_prev_reg <= 1'b1;
         shift_reg <= '0;
         bit_cnt_reg <= 6'h00;
      end else begin
         sclk_prev_reg <= CFG_IF.sclk;
         cs_prev_reg <= CFG_IF.cs_n;
         if (CFG_IF.cs_n) begin
            bit_cnt_reg <= 6'h00;
         end else if (sclk_rise) begin
            shift_reg <= {shift_reg[46:0], CFG_IF.mosi};
            // short or long frames are dropped at chip-select release
            if (bit_cnt_reg != 6'h3F) begin
               bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
         end
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (!RST_N_IN) begin
         setup_reg <= '0;
         frac_reg <= '0;
         restart_reg <= 1'b0;
         gain_reg <= 1'b0;
      end else if (frame_ok) begin
         if (wr_addr == `OFS_SETUP) begin
            setup_reg <= wr_data;
         end
         if (wr_addr == `OFS_DIVIDER) begin
            frac_reg <= wr_data[`FRAC_HI:`FRAC_LO];
         end
         if (wr_addr == `OFS_RESTART) begin
            restart_reg <= wr_data[`RESTART_BIT];
         end
         if (wr_addr == `OFS_GAIN) begin
            gain_reg <= wr_data[`GAIN_BIT];
         end
      end
   end

   // configuration fields
   wire [2:0] dith_ord = setup_reg[`DITH_ORD_HI:`DITH_ORD_LO];
   wire [4:0] dith_shift = setup_reg[`DITH_SHIFT_HI:`DITH_SHIFT_LO];
   wire [2:0] mash_ord = setup_reg[`MASH_HI:`MASH_LO];
   wire [1:0] interp = setup_reg[`INTERP_HI:`INTERP_LO];

   // fraction split into interpolated phase part and modulated remainder
   wire [1:0] drop_bits = (interp == 2'h0) ? 2'h0 : interp - 2'h1;
   wire [FRAC_W-1:0] used_frac = frac_reg & ({FRAC_W{1'b1}} << drop_bits);
   wire [2:0] phase_mask = 3'h7 << interp;
   wire [2:0] phase_part = used_frac[FRAC_W-1 -: `PHASE_BITS] & phase_mask;
   wire [FRAC_W-1:0] low_part = used_frac & {~phase_mask, {(FRAC_W-`PHASE_BITS){1'b1}}};
   wire [1:0] phase_bits = 2'h3 - interp;
   wire [FRAC_W-1:0] mod_in = low_part << phase_bits;
   wire mod_active = (mash_ord != 3'h0) & (low_part != '0);

   // binomial weight of a tap in an n-th order difference
   function automatic logic signed [5:0] binom(input logic [2:0] n, input int k);
      logic [5:0] num;
      num = 6'h01;
      for (int i = 0; i < 5; i++) begin
         if (i < k) begin
            num = 6'((int'(num) * (int'(n) - i)) / (i + 1));
         end
      end
      binom = ((k % 2) == 1) ? -$signed(num) : $signed(num);
   endfunction

   // dither: n-th difference of a random bit stream, high-pass and zero mean
   logic [15:0] lfsr_reg;
   logic [5:0] rnd_hist_reg;
   logic signed [5:0] dith_val;

   always_comb begin
      dith_val = 6'sh00;
      for (int k = 0; k <= 5; k++) begin
         if ((dith_ord != 3'h0) && (k <= int'(dith_ord)) && rnd_hist_reg[k]) begin
            dith_val = dith_val + binom(dith_ord, k);
         end
      end
   end

   wire signed [30:0] dith_scaled = 31'(dith_val) <<< dith_shift;

   // cascaded accumulators, one carry per stage
   logic [FRAC_W-1:0] acc_reg [4];
   logic [FRAC_W-1:0] acc_next [4];
   logic [3:1] carry;
   logic [2:0] c_hist_reg [4];
   wire signed [30:0] sum1 = $signed({3'h0, acc_reg[0]}) + $signed({3'h0, mod_in}) + dith_scaled;
   wire signed [2:0] carry1 = sum1[30:28];

   always_comb begin
      logic [FRAC_W:0] s;
      s = '0;
      acc_next[0] = sum1[FRAC_W-1:0];
      carry = 3'h0;
      for (int k = 1; k < 4; k++) begin
         s = {1'b0, acc_reg[k]} + {1'b0, acc_next[k-1]};
         acc_next[k] = s[FRAC_W-1:0];
         carry[k] = s[FRAC_W] & (k < int'(mash_ord));
      end
   end

   // higher stage carries are differenced so they average to zero
   wire signed [7:0] d2 = 8'(carry[1]) - 8'(c_hist_reg[1][0]);
   wire signed [7:0] d3 = 8'(carry[2]) - 8'sd2 * 8'(c_hist_reg[2][0]) + 8'(c_hist_reg[2][1]);
   wire signed [7:0] d4 = 8'(carry[3]) - 8'sd3 * 8'(c_hist_reg[3][0])
                        + 8'sd3 * 8'(c_hist_reg[3][1]) - 8'(c_hist_reg[3][2]);
   wire signed [7:0] step_sum = 8'(carry1) + d2 + d3 + d4;

   always_ff @(posedge REF_CLK_IN) begin
      if (!RST_N_IN) begin
         lfsr_reg <= `LFSR_SEED;
         rnd_hist_reg <= 6'h00;
         for (int k = 0; k < 4; k++) begin
            acc_reg[k] <= '0;
            c_hist_reg[k] <= 3'h0;
         end
      end else begin
         lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
         if (restart_reg) begin
            rnd_hist_reg <= 6'h00;
            for (int k = 0; k < 4; k++) begin
               acc_reg[k] <= '0;
               c_hist_reg[k] <= 3'h0;
            end
         end else if (FB_CYCLE_IN && mod_active) begin
            rnd_hist_reg <= {rnd_hist_reg[4:0], lfsr_reg[0]};
            for (int k = 0; k < 4; k++) begin
               acc_reg[k] <= acc_next[k];
            end
            for (int k = 1; k < 4; k++) begin
               c_hist_reg[k] <= {c_hist_reg[k][1:0], carry[k]};
            end
         end
      end
   end

   // outputs and startup sync
   logic sync_pending_reg;

   always_ff @(posedge REF_CLK_IN) begin
      if (!RST_N_IN) begin
         DIV_STEP_OUT <= 6'sh00;
         FRAC_PHASE_OUT <= 3'h0;
         INTERP_ORDER_OUT <= 2'h0;
         DIV_RESTART_OUT <= 1'b0;
         OSC_BAND_OUT <= 5'h00;
         OSC_GAIN_BAND_OUT <= 1'b0;
         SYNC_PULSE_OUT <= 1'b0;
         sync_pending_reg <= 1'b1;
      end else begin
         FRAC_PHASE_OUT <= phase_part;
         INTERP_ORDER_OUT <= interp;
         DIV_RESTART_OUT <= restart_reg;
         OSC_BAND_OUT <= setup_reg[`BAND_HI:`BAND_LO];
         OSC_GAIN_BAND_OUT <= gain_reg;
         SYNC_PULSE_OUT <= 1'b0;
         if (restart_reg || !mod_active) begin
            DIV_STEP_OUT <= 6'sh00;
         end else if (FB_CYCLE_IN) begin
            DIV_STEP_OUT <= step_sum[5:0];
         end
         // the power-up sync fires on the first divider cycle after reset
         if (FB_CYCLE_IN && sync_pending_reg) begin
            sync_pending_reg <= 1'b0;
            SYNC_PULSE_OUT <= ~setup_reg[`SYNC_INH_BIT];
         end
      end
   end

endmodule // fractional_divider_modulation_ctrl

// >>> hw/fracdiv_host_ctrl.sv
`timescale 1ns/1ps
`include "fracdiv_params.svh"
module fracdiv_host_ctrl #(
   parameter int SCLK_HALF = `SCLK_HALF_CYC
) (
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RST_N_IN,
   // configuration request
   input wire logic CFG_VALID_IN,
   output logic CFG_READY_OUT,
   input wire logic [7:0] INT_DIV_IN,
   input wire logic [27:0] FRACTION_IN,
   input wire logic [2:0] DITHER_ORDER_IN,
   input wire logic [2:0] NOISE_SHAPER_ORDER_IN,
   input wire logic [4:0] OSC_BAND_IN,
   input wire logic SYNC_INHIBIT_IN,
   input wire logic [1:0] INTERP_ORDER_IN,
   // serial configuration link
   serial_cfg_if.host CFG_IF
);

   // trailing zeros of the fraction give the half-lsb dither scale
   function automatic logic [4:0] trailing_zeros(input logic [27:0] v);
      trailing_zeros = 5'h1F;
      for (int i = 27; i >= 0; i--) begin
         if (v[i]) begin
            trailing_zeros = 5'(i);
         end
      end
   endfunction

   wire [2:0] mash_s = (NOISE_SHAPER_ORDER_IN > `MAX_MASH_ORD) ? `MAX_MASH_ORD
                                                               : NOISE_SHAPER_ORDER_IN;
   wire [2:0] dith_lim = (DITHER_ORDER_IN > `MAX_DITH_ORD) ? `MAX_DITH_ORD
                                                          : DITHER_ORDER_IN;
   wire [2:0] dith_s = (mash_s == 3'h0) ? 3'h0 : dith_lim;
   wire [4:0] tz = trailing_zeros(FRACTION_IN);
   wire [4:0] shift_s = (tz > 5'(dith_s)) ? tz : 5'(dith_s) + 5'h01;
   wire gain_s = (OSC_BAND_IN >= `GAIN_BAND_LO) && (OSC_BAND_IN <= `GAIN_BAND_HI);

   logic [`DATA_W-1:0] div_word_reg;
   logic [`DATA_W-1:0] setup_word_reg;
   logic gain_reg;
   logic restart_due_reg;
   logic [2:0] last_mash_reg;
   logic [35:0] last_div_reg;
   logic first_reg;
   fracdiv_pkg::host_state_e state_reg;
   logic [2:0] idx_reg;
   fracdiv_pkg::frame_t frame_reg;
   logic [5:0] bit_cnt_reg;
   logic [7:0] div_cnt_reg;

   wire take = CFG_VALID_IN & CFG_READY_OUT;
   wire changed = first_reg | (mash_s != last_mash_reg) | ({INT_DIV_IN, FRACTION_IN} != last_div_reg);
   wire [2:0] last_idx = restart_due_reg ? 3'h4 : 3'h2;
   wire half_done = (div_cnt_reg == 8'(SCLK_HALF - 1));

   // words in send order: divider, setup, gain band, restart set, restart clear
   logic [47:0] next_frame;
   always_comb begin
      case (idx_reg)
         3'h0: next_frame = {`OFS_DIVIDER, div_word_reg};
         3'h1: next_frame = {`OFS_SETUP, setup_word_reg};
         3'h2: next_frame = {`OFS_GAIN, 40'(gain_reg) << `GAIN_BIT};
         3'h3: next_frame = {`OFS_RESTART, 40'h1 << `RESTART_BIT};
         default: next_frame = {`OFS_RESTART, 40'h0};
      endcase
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (!RST_N_IN) begin
         div_word_reg <= '0;
         setup_word_reg <= '0;
         gain_reg <= 1'b0;
         restart_due_reg <= 1'b0;
         last_mash_reg <= 3'h0;
         last_div_reg <= '0;
         first_reg <= 1'b1;
      end else if (take) begin
         div_word_reg <= {INT_DIV_IN, FRACTION_IN, `DIV_POWER_BITS};
         setup_word_reg <= {dith_s, shift_s, mash_s, OSC_BAND_IN, SYNC_INHIBIT_IN,
                            INTERP_ORDER_IN, 21'h00000};
         gain_reg <= gain_s;
         restart_due_reg <= changed;
         last_mash_reg <= mash_s;
         last_div_reg <= {INT_DIV_IN, FRACTION_IN};
         first_reg <= 1'b0;
      end
   end

   // serial engine: data changes on the falling edge, device samples on rising
   always_ff @(posedge REF_CLK_IN) begin
      if (!RST_N_IN) begin
         state_reg <= fracdiv_pkg::H_IDLE;
         idx_reg <= 3'h0;
         frame_reg <= '0;
         bit_cnt_reg <= 6'h00;
         div_cnt_reg <= 8'h00;
         CFG_READY_OUT <= 1'b0;
         CFG_IF.sclk <= 1'b0;
         CFG_IF.cs_n <= 1'b1;
         CFG_IF.mosi <= 1'b0;
      end else begin
         case (state_reg)
            fracdiv_pkg::H_IDLE: begin
               CFG_READY_OUT <= 1'b1;
               if (take) begin
                  CFG_READY_OUT <= 1'b0;
                  idx_reg <= 3'h0;
                  state_reg <= fracdiv_pkg::H_LOAD;
               end
            end
            fracdiv_pkg::H_LOAD: begin
               frame_reg <= {next_frame[46:0], 1'b0};
               CFG_IF.mosi <= next_frame[47];
               CFG_IF.cs_n <= 1'b0;
               bit_cnt_reg <= 6'h00;
               div_cnt_reg <= 8'h00;
               state_reg <= fracdiv_pkg::H_SHIFT;
            end
            fracdiv_pkg::H_SHIFT: begin
               div_cnt_reg <= half_done ? 8'h00 : div_cnt_reg + 8'h01;
               if (half_done) begin
                  CFG_IF.sclk <= ~CFG_IF.sclk;
                  if (CFG_IF.sclk) begin
                     bit_cnt_reg <= bit_cnt_reg + 6'h01;
                     CFG_IF.mosi <= frame_reg[47];
                     frame_reg <= {frame_reg[46:0], 1'b0};
                     if (bit_cnt_reg == `FRAME_BITS - 6'h01) begin
                        CFG_IF.cs_n <= 1'b1;
                        state_reg <= fracdiv_pkg::H_GAP;
                     end
                  end
               end
            end
            fracdiv_pkg::H_GAP: begin
               div_cnt_reg <= half_done ? 8'h00 : div_cnt_reg + 8'h01;
               if (half_done) begin
                  idx_reg <= idx_reg + 3'h1;
                  state_reg <= (idx_reg == last_idx) ? fracdiv_pkg::H_IDLE
                                                     : fracdiv_pkg::H_LOAD;
               end
            end
            default: state_reg <= fracdiv_pkg::H_IDLE;
         endcase
      end
   end

endmodule // fracdiv_host_ctrl

// >>> testbench/fracdiv_checker.sv
`timescale 1ns/1ps
module fracdiv_checker (
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RST_N_IN,
   // serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   // divider side
   input wire logic FB_CYCLE_IN,
   input wire fracdiv_pkg::div_step_t DIV_STEP_OUT,
   input wire logic [2:0] FRAC_PHASE_OUT,
   input wire logic [1:0] INTERP_ORDER_OUT,
   input wire logic DIV_RESTART_OUT,
   input wire logic SYNC_PULSE_OUT
);
   localparam int RESTART_MAX = 400;
   logic [6:0] bits_reg;
   logic [6:0] bits_next;
   logic sclk_reg;
   wire logic sclk_rise = sclk && !sclk_reg;
   // phase bits finer than the interpolation step must read zero
   wire logic [2:0] phase_keep = 3'h7 << INTERP_ORDER_OUT;
   assign bits_next = cs_n ? 7'h00 : (sclk_rise ? bits_reg + 7'h01 : bits_reg);
   always_ff @(posedge REF_CLK_IN) begin
      bits_reg <= RST_N_IN ? bits_next : 7'h00;
      sclk_reg <= RST_N_IN ? sclk : 1'b0;
   end
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   sequence frame_end;
      $rose(cs_n);
   endsequence
   sequence restart_held;
      DIV_RESTART_OUT [*2];
   endsequence
   sequence sync_once;
      SYNC_PULSE_OUT ##1 !SYNC_PULSE_OUT;
   endsequence
   sclk_idle_a: assert property (cs_n |-> !sclk)
      else $error("serial clock active outside a frame");
   mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("serial data moved while clock high");
   frame_len_a: assert property (frame_end |-> bits_reg == 7'h30)
      else $error("frame not 48 bits long");
   frame_gap_a: assert property (frame_end |=> cs_n)
      else $error("no idle cycle between frames");
   sync_pulse_a: assert property (SYNC_PULSE_OUT |-> $past(FB_CYCLE_IN) ##0 sync_once)
      else $error("sync pulse not one cycle after divider cycle");
   step_moment_a: assert property ($changed(DIV_STEP_OUT) |->
      $past(FB_CYCLE_IN) || DIV_STEP_OUT == 6'sh00)
      else $error("divide step moved between divider cycles");
   restart_clear_a: assert property (restart_held |-> DIV_STEP_OUT == 6'sh00)
      else $error("divide step not cleared by restart");
   restart_pulse_a: assert property ($rose(DIV_RESTART_OUT) |->
      ##[1:RESTART_MAX] !DIV_RESTART_OUT)
      else $error("restart held too long");
   phase_mask_a: assert property ((FRAC_PHASE_OUT & ~phase_keep) == 3'h0)
      else $error("phase bits finer than interpolation");
   step_range_a: assert property ($signed(DIV_STEP_OUT) >= -8 &&
      $signed(DIV_STEP_OUT) <= 9)
      else $error("divide step out of range");
endmodule // fracdiv_checker

// >>> testbench/fractional_divider_modulation_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fails++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end
module fractional_divider_modulation_ctrl_test;
   localparam int LIMIT = 40000;
   typedef struct {
      logic [7:0] int_div;
      logic [27:0] frac;
      logic [2:0] dith, mash;
      logic [4:0] band;
      logic inh;
      logic [1:0] interp;
      logic [2:0] e_dith;
      logic [4:0] e_shift;
      logic [2:0] e_mash;
      logic e_gain;
      logic [2:0] e_phase;
   } row_s;
   row_s rows [5] = '{
      '{8'h40, 28'h8000000, 3'h1, 3'h1, 5'h0D, 1'b0, 2'h0, 3'h1, 5'h1B, 3'h1, 1'b0, 3'h4},
      '{8'h41, 28'hE000010, 3'h7, 3'h6, 5'h0E, 1'b1, 2'h1, 3'h5, 5'h06, 3'h4, 1'b1, 3'h6},
      '{8'h42, 28'hA000000, 3'h3, 3'h0, 5'h1B, 1'b0, 2'h2, 3'h0, 5'h19, 3'h0, 1'b1, 3'h4},
      '{8'h43, 28'h0000000, 3'h2, 3'h2, 5'h1C, 1'b1, 2'h3, 3'h2, 5'h1F, 3'h2, 1'b0, 3'h0},
      '{8'h44, 28'h6000001, 3'h0, 3'h0, 5'h00, 1'b0, 2'h2, 3'h0, 5'h01, 3'h0, 1'b0, 3'h0}};
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic fb = 1'b0;
   logic valid = 1'b0;
   logic ready;
   row_s cur;
   fracdiv_pkg::div_step_t step;
   logic [2:0] phase;
   logic [1:0] interp_out;
   logic restart, gain, sync;
   logic [4:0] band_out;
   logic [47:0] shreg, setup_word;
   logic signed [15:0] acc;
   int frames, syncs, checks, fails, cyc;
   bit restart_seen;
   serial_cfg_if cfg();
   fracdiv_host_ctrl #(.SCLK_HALF(2)) i_fracdiv_host_ctrl (.REF_CLK_IN(ref_clk),
      .RST_N_IN(rst_n), .CFG_VALID_IN(valid), .CFG_READY_OUT(ready),
      .INT_DIV_IN(cur.int_div), .FRACTION_IN(cur.frac), .DITHER_ORDER_IN(cur.dith),
      .NOISE_SHAPER_ORDER_IN(cur.mash), .OSC_BAND_IN(cur.band),
      .SYNC_INHIBIT_IN(cur.inh), .INTERP_ORDER_IN(cur.interp), .CFG_IF(cfg));
   fractional_divider_modulation_ctrl i_fractional_divider_modulation_ctrl (
      .REF_CLK_IN(ref_clk), .RST_N_IN(rst_n), .FB_CYCLE_IN(fb), .CFG_IF(cfg),
      .DIV_STEP_OUT(step), .FRAC_PHASE_OUT(phase), .INTERP_ORDER_OUT(interp_out),
      .DIV_RESTART_OUT(restart), .OSC_BAND_OUT(band_out), .OSC_GAIN_BAND_OUT(gain),
      .SYNC_PULSE_OUT(sync));
   fracdiv_checker i_fracdiv_checker (.REF_CLK_IN(ref_clk), .RST_N_IN(rst_n),
      .sclk(cfg.sclk), .cs_n(cfg.cs_n), .mosi(cfg.mosi), .FB_CYCLE_IN(fb),
      .DIV_STEP_OUT(step), .FRAC_PHASE_OUT(phase), .INTERP_ORDER_OUT(interp_out),
      .DIV_RESTART_OUT(restart), .SYNC_PULSE_OUT(sync));
   always #50 ref_clk = ~ref_clk;
   // wire monitor: rebuild each frame from the serial lines
   always @(posedge cfg.sclk) begin
      if (cfg.cs_n === 1'b0) shreg = {shreg[46:0], cfg.mosi};
   end
   always @(posedge cfg.cs_n) begin
      frames++;
      if (shreg[47:40] === 8'h07) setup_word = shreg;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (restart === 1'b1) restart_seen = 1'b1;
      if (sync === 1'b1) syncs++;
      if (cyc == LIMIT) begin
         fails++;
         tally_and_finish;
      end
   end
   task automatic tally_and_finish;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic do_reset;
      rst_n = 1'b0;
      repeat (5) @(posedge ref_clk);
      #10 rst_n = 1'b1;
      syncs = 0;
   endtask
   // one request, then wait for the whole frame sequence to land
   task automatic configure(input row_s r);
      int n;
      n = 0;
      frames = 0;
      restart_seen = 1'b0;
      @(posedge ref_clk);
      #10;
      while (ready !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         #10 n++;
      end
      cur = r;
      valid = 1'b1;
      @(posedge ref_clk);
      #10 valid = 1'b0;
      `CHK(ready, 1'b0)
      n = 0;
      while (ready !== 1'b1 && n < 3000) begin
         @(posedge ref_clk);
         #10 n++;
      end
      `CHK(ready, 1'b1)
      repeat (3) @(posedge ref_clk);
      #10;
   endtask
   // three cycles per divider cycle; step sampled once it has settled
   task automatic pulse_fb(input int n);
      acc = 16'sh0000;
      repeat (n) begin
         fb = 1'b1;
         @(posedge ref_clk);
         #10 fb = 1'b0;
         @(posedge ref_clk);
         #10 acc = acc + step;
         @(posedge ref_clk);
         #10;
      end
   endtask
   task automatic mod_case(input logic [27:0] f, input logic [2:0] d, input logic [2:0] m,
                           input logic [1:0] s, input int n);
      row_s r;
      r = rows[0];
      r.frac = f;
      r.dith = d;
      r.mash = m;
      r.interp = s;
      configure(r);
      pulse_fb(n);
   endtask
   initial begin
      cur = rows[0];
      do_reset;
      pulse_fb(1);
      `CHK(syncs, 1)
      $display("test startup sync done");
      for (int i = 0; i < 5; i++) begin
         configure(rows[i]);
         `CHK(setup_word, {8'h07, rows[i].e_dith, rows[i].e_shift, rows[i].e_mash,
            rows[i].band, rows[i].inh, rows[i].interp, 21'h00000})
         `CHK(band_out, rows[i].band)
         `CHK(gain, rows[i].e_gain)
         `CHK(interp_out, rows[i].interp)
         `CHK(phase, rows[i].e_phase)
         `CHK(frames, 5)
         `CHK({restart_seen, restart}, 2'h2)
         $display("test row %0d done", i);
      end
      mod_case(28'h8000000, 3'h0, 3'h1, 2'h3, 16);
      `CHK(acc, 16'sh0008)
      mod_case(28'h8000000, 3'h0, 3'h1, 2'h0, 16);
      `CHK(acc, 16'sh0000)
      mod_case(28'h8000000, 3'h0, 3'h0, 2'h3, 16);
      `CHK(acc, 16'sh0000)
      mod_case(28'h8000000, 3'h1, 3'h1, 2'h3, 64);
      // bounded by accumulator and dither history, not exact
      `CHK(acc >= 16'sd29 && acc <= 16'sd35, 1'b1)
      // fourth order: the differenced carries telescope to zero after 16 steps of a half
      mod_case(28'h8000000, 3'h0, 3'h4, 2'h3, 16);
      `CHK(acc, 16'sh0008)
      $display("test modulation done");
      cur.band = 5'h05;
      configure(cur);
      `CHK(frames, 3)
      `CHK(restart_seen, 1'b0)
      $display("test short update done");
      do_reset;
      cur.inh = 1'b1;
      configure(cur);
      pulse_fb(2);
      `CHK(syncs, 0)
      $display("test sync inhibit done");
      tally_and_finish;
   end
endmodule // fractional_divider_modulation_ctrl_test
